// *** core/dbg_cmp_map.svh ***
// register offsets, field positions and reset values of the comparator a block
`ifndef DBG_CMP_MAP_SVH
`define DBG_CMP_MAP_SVH
`define CMP_A_CTRL_OFFSET 12'h110
`define CMP_A_ADDR_OFFSET 12'h114
`define CMP_A_DATA_OFFSET 12'h118
`define ARM_CTRL_OFFSET 12'h100
`define STATE_OFFSET 12'h104
`define BIT_INVERT_DATA 6
`define BIT_PC_SELECT 5
`define BIT_DIR_VALUE 3
`define BIT_DIR_ENABLE 2
`define BIT_CMP_ON 0
`define CMP_A_CTRL_WMASK 8'h6D
`define CMP_A_CTRL_RESET 8'h00
`define CMP_A_ADDR_RESET 16'h0000
`define CMP_A_DATA_RESET 16'h0000
`define STATE_DISARMED 3'h0
`define STATE_FINAL 3'h4
`endif

// *** core/dbg_cmp_pkg.sv ***
// types shared by the comparator a block
package dbg_cmp_pkg;
    typedef enum logic [2:0] {
        SEQ_DISARMED = 3'h0,
        SEQ_STATE1 = 3'h1,
        SEQ_STATE2 = 3'h2,
        SEQ_STATE3 = 3'h3,
        SEQ_FINAL = 3'h4
    } seq_state_t;
endpackage

// *** core/match_if.sv ***
// carrier between control register and match logic
`timescale 1ns/1ns
interface match_if;
    logic [7:0] ctrl;
    logic [15:0] cmp_addr;
    logic [15:0] cmp_data;
    logic match;
    modport ctl(output ctrl, output cmp_addr, output cmp_data, input match);
    modport cmp(input ctrl, input cmp_addr, input cmp_data, output match);
endinterface

// *** core/cmp_a_match.sv ***
// match evaluation of comparator a
`timescale 1ns/1ns
`include "dbg_cmp_map.svh"
module cmp_a_match (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic [15:0] bus_data_i,
    input wire logic bus_valid_i,
    input wire logic bus_read_i,
    input wire logic [15:0] pc_i,
    input wire logic pc_valid_i,
    match_if.cmp m
);
    logic match_reg;
    logic match_next;
    logic addr_hit;
    logic data_hit;
    logic dir_hit;
    always_comb begin
        match_next = 1'b0;
        addr_hit = 1'b0;
        data_hit = 1'b0;
        dir_hit = 1'b1;
        if (m.ctrl[`BIT_PC_SELECT]) begin // RQ5
            // direction and data tests drop out for pc compares
            match_next = pc_valid_i && (pc_i == m.cmp_addr); // RQ4 RQ7
        end else begin
            addr_hit = bus_valid_i && (bus_addr_i == m.cmp_addr);
            data_hit = (bus_data_i == m.cmp_data) ^ m.ctrl[`BIT_INVERT_DATA]; // RQ3
            if (m.ctrl[`BIT_DIR_ENABLE]) begin // RQ7
                dir_hit = (bus_read_i == m.ctrl[`BIT_DIR_VALUE]); // RQ6
            end
            match_next = addr_hit && data_hit && dir_hit;
        end
        if (!m.ctrl[`BIT_CMP_ON]) begin
            match_next = 1'b0; // RQ8
        end
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            match_reg <= 1'b0;
        end else begin
            match_reg <= match_next;
        end
    end
    assign m.match = match_reg;
endmodule

// *** core/dbg_cmp_a.sv ***
// debug comparator a control with apb register access
//
// What this block does
// RQ1: state flag 000 disarmed, 1-3 intermediate, 100 final
// RQ2: control readable always, writable only when disarmed
// RQ3: bit 6 selects match on equal or differ
// RQ4: pc select makes data inversion ignored
// RQ5: bit 5 selects data or pc addresses
// RQ6: bit 3 write clear, read set, conditionally
// RQ7: bit 2 enables direction, ignored for pc
// RQ8: bit 0 on; off gives no match
// RQ9: bits 7, 4, 1 read zero
`timescale 1ns/1ns
`include "dbg_cmp_map.svh"
module dbg_cmp_a
    import dbg_cmp_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [15:0] bus_addr_i,
    input wire logic [15:0] bus_data_i,
    input wire logic bus_valid_i,
    input wire logic bus_read_i,
    input wire logic [15:0] pc_i,
    input wire logic pc_valid_i,
    output logic match_o,
    output logic [2:0] sequencer_state_flag_o
);
    match_if mi();
    // comparator setup registers
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [15:0] addr_reg;
    logic [15:0] addr_next;
    logic [15:0] data_reg;
    logic [15:0] data_next;
    // sequencer state
    seq_state_t seq_reg;
    seq_state_t seq_next;
    // bus response
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic ready_reg;
    logic ready_next;
    logic err_reg;
    logic err_next;
    // armed match
    logic match_reg;
    logic match_next;
    // access decode
    logic setup;
    logic armed;
    logic wr_open;
    logic sel_ctrl;
    logic sel_addr;
    logic sel_data;
    logic sel_arm;
    logic sel_state;
    logic sel_none;
    assign setup = psel_i && !penable_i;
    assign armed = (seq_reg != SEQ_DISARMED);
    // setup registers lock while armed so a running compare cannot be retargeted
    assign wr_open = setup && pwrite_i && !armed; // RQ2
    // one-hot decode of the word address, used in the setup cycle only
    always_comb begin
        sel_ctrl = 1'b0;
        sel_addr = 1'b0;
        sel_data = 1'b0;
        sel_arm = 1'b0;
        sel_state = 1'b0;
        sel_none = 1'b0;
        case (paddr_i)
            `CMP_A_CTRL_OFFSET: begin
                sel_ctrl = 1'b1;
            end
            `CMP_A_ADDR_OFFSET: begin
                sel_addr = 1'b1;
            end
            `CMP_A_DATA_OFFSET: begin
                sel_data = 1'b1;
            end
            `ARM_CTRL_OFFSET: begin
                sel_arm = 1'b1;
            end
            `STATE_OFFSET: begin
                sel_state = 1'b1;
            end
            default: begin
                sel_none = 1'b1;
            end
        endcase
    end
    // setup registers: only the implemented control bits are stored
    always_comb begin
        ctrl_next = ctrl_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        if (wr_open && sel_ctrl) begin // RQ2
            ctrl_next = pwdata_i[7:0] & `CMP_A_CTRL_WMASK; // RQ9
        end
        if (wr_open && sel_addr) begin
            addr_next = pwdata_i[15:0];
        end
        if (wr_open && sel_data) begin
            data_next = pwdata_i[15:0];
        end
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_reg <= `CMP_A_CTRL_RESET;
            addr_reg <= `CMP_A_ADDR_RESET;
            data_reg <= `CMP_A_DATA_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
        end
    end
    // sequencer: arm enters state1, each armed match steps one state on to final
    always_comb begin
        seq_next = seq_reg;
        case (seq_reg)
            SEQ_DISARMED: begin
                seq_next = SEQ_DISARMED;
            end
            SEQ_STATE1: begin
                if (match_reg) begin
                    seq_next = SEQ_STATE2;
                end
            end
            SEQ_STATE2: begin
                if (match_reg) begin
                    seq_next = SEQ_STATE3;
                end
            end
            SEQ_STATE3: begin
                if (match_reg) begin
                    seq_next = SEQ_FINAL;
                end
            end
            SEQ_FINAL: begin
                seq_next = SEQ_FINAL;
            end
            default: begin
                // reserved codes are never entered; fall back to disarmed
                seq_next = SEQ_DISARMED; // RQ1
            end
        endcase
        // software arming or disarming wins over a match in the same cycle
        if (setup && pwrite_i && sel_arm) begin
            if (pwdata_i[0]) begin
                seq_next = SEQ_STATE1;
            end else begin
                seq_next = SEQ_DISARMED;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            seq_reg <= SEQ_DISARMED;
        end else begin
            seq_reg <= seq_next;
        end
    end
    // bus response: no wait states, read data held until the next access
    always_comb begin
        rdata_next = rdata_reg;
        ready_next = 1'b0;
        err_next = 1'b0;
        if (setup) begin
            ready_next = 1'b1;
            rdata_next = 32'h0000_0000;
            if (sel_ctrl) begin
                rdata_next = {24'h00_0000, ctrl_reg & `CMP_A_CTRL_WMASK}; // RQ2 RQ9
            end
            if (sel_addr) begin
                rdata_next = {16'h0000, addr_reg};
            end
            if (sel_data) begin
                rdata_next = {16'h0000, data_reg};
            end
            if (sel_arm) begin
                rdata_next = {31'h0000_0000, armed};
            end
            if (sel_state) begin
                rdata_next = {29'h0000_0000, seq_reg}; // RQ1
            end
            // unmapped words answer with an error and read as zero
            err_next = sel_none;
        end
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_reg <= 32'h0000_0000;
            ready_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            ready_reg <= ready_next;
            err_reg <= err_next;
        end
    end
    // raw compare is qualified once more so match_o only shows armed hits
    always_comb begin
        match_next = mi.match && armed;
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            match_reg <= 1'b0;
        end else begin
            match_reg <= match_next;
        end
    end
    assign mi.ctrl = ctrl_reg;
    assign mi.cmp_addr = addr_reg;
    assign mi.cmp_data = data_reg;
    cmp_a_match u_match (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .bus_addr_i(bus_addr_i),
        .bus_data_i(bus_data_i),
        .bus_valid_i(bus_valid_i),
        .bus_read_i(bus_read_i),
        .pc_i(pc_i),
        .pc_valid_i(pc_valid_i),
        .m(mi.cmp)
    );
    assign prdata_o = rdata_reg;
    assign pready_o = ready_reg;
    assign pslverr_o = err_reg;
    assign match_o = match_reg;
    assign sequencer_state_flag_o = seq_reg; // RQ1
endmodule

// *** tb/dbg_cmp_a_chk.sv ***
// concurrent checks on the ports of comparator a control
`timescale 1ns/1ns
module dbg_cmp_a_chk (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic match_o,
    input wire logic [2:0] sequencer_state_flag_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_ctrl_read;
        pready_o && !pwrite_i && paddr_i == 12'h110;
    endsequence
    a_ready_next: assert property (s_setup |=> pready_o)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready held");
    a_idle_quiet: assert property (!psel_i |=> !pready_o)
        else $error("ready without select");
    a_ctrl_noerr: assert property (s_ctrl_read |-> !pslverr_o)
        else $error("error on control read");
    a_unused_zero: assert property (s_ctrl_read |-> (prdata_o & 32'hFFFFFF92) == 32'h0)
        else $error("unused control bits set");
    a_state_legal: assert property (sequencer_state_flag_o <= 3'h4)
        else $error("reserved state code");
    a_reset_flag: assert property ($past(reset_i) |-> sequencer_state_flag_o == 3'h0)
        else $error("state not disarmed after reset");
    a_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("error outside ready");
    // match pipeline is two deep, so four disarmed edges leave it drained
    a_disarm_quiet: assert property ((sequencer_state_flag_o == 3'h0)[*4] |-> !match_o)
        else $error("match while disarmed");
endmodule

// *** tb/dbg_cmp_a_tb_top.sv ***
// self-checking bench of comparator a control
`timescale 1ns/1ns
module dbg_cmp_a_tb_top;
    logic clk_i = 0, reset_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, err;
    logic [11:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0, prdata_o, rdata;
    logic [15:0] bus_addr_i = 16'h1234, bus_data_i = 16'h00A5, pc_i = 16'h1234;
    logic bus_valid_i = 0, bus_read_i = 0, pc_valid_i = 0, pready_o, pslverr_o, match_o;
    logic [2:0] sequencer_state_flag_o;
    // {control, read, bus valid, pc valid, expected match}
    logic [11:0] cases [9] = '{12'h015, 12'h004, 12'h414, 12'h213, 12'h613,
        12'h055, 12'h05C, 12'h0DD, 12'h2D3};
    int fail_count = 0, n_checks = 0;
    dbg_cmp_a dut (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .bus_addr_i(bus_addr_i),
        .bus_data_i(bus_data_i),
        .bus_valid_i(bus_valid_i),
        .bus_read_i(bus_read_i),
        .pc_i(pc_i),
        .pc_valid_i(pc_valid_i),
        .match_o(match_o),
        .sequencer_state_flag_o(sequencer_state_flag_o)
    );
    initial forever #50 clk_i = ~clk_i;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // request stands until pready is seen high at a rising edge; data is taken there
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        // no cycle count assumed: only the watchdog ends a hung access
        do @(posedge clk_i); while (pready_o !== 1'b1);
        rdata = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        apb(0, 12'h110, 0);
        chk("ctrl reset", 32'h0, rdata);
        apb(0, 12'h104, 0);
        chk("state disarmed", 32'h0, rdata);
        apb(1, 12'h114, 32'h1234);
        apb(1, 12'h118, 32'h00A5);
        apb(1, 12'h110, 32'hFFFFFFFF);
        apb(0, 12'h110, 0);
        chk("ctrl unused", 32'h6D, rdata);
        apb(1, 12'h100, 1);
        apb(0, 12'h104, 0);
        chk("state armed", 32'h1, rdata);
        chk("flag pin", 32'h1, {29'h0, sequencer_state_flag_o});
        apb(1, 12'h110, 0);
        apb(0, 12'h110, 0);
        chk("ctrl locked", 32'h6D, rdata);
        apb(0, 12'h3F0, 0);
        chk("unmapped err", 32'h1, {31'h0, err});
        foreach (cases[i]) begin
            apb(1, 12'h100, 0);
            apb(1, 12'h110, {24'h0, cases[i][11:4]});
            @(posedge clk_i) {bus_read_i, bus_valid_i, pc_valid_i} <= cases[i][3:1];
            apb(1, 12'h100, 1);
            repeat (4) @(posedge clk_i);
            @(negedge clk_i);
            chk("match", {31'h0, cases[i][0]}, {31'h0, match_o});
            // a held match walks state1 to final in three edges
            chk("flag", cases[i][0] ? 32'h4 : 32'h1, {29'h0, sequencer_state_flag_o});
        end
        test_done;
    end
    initial begin
        #200000;
        fail_count++;
        test_done;
    end
endmodule
bind dbg_cmp_a dbg_cmp_a_chk chk (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .match_o(match_o),
    .sequencer_state_flag_o(sequencer_state_flag_o)
);
